//--- rtl/amcs_consts.vh
// constants for the amplifier mode and clock select block
`ifndef AMCS_CONSTS_VH
`define AMCS_CONSTS_VH

// register byte offsets
`define AMCS_ADDR_CTRL 12'h000
`define AMCS_ADDR_STRAP 12'h004
`define AMCS_ADDR_STATUS 12'h008
`define AMCS_ADDR_PWM 12'h00C

// control register fields
`define AMCS_CTRL_ACTIVE 0
`define AMCS_CTRL_MUTE 1

// strap register fields
`define AMCS_STRAP_ADS_RES 0
`define AMCS_STRAP_OSC_RES 1

// status register fields
`define AMCS_STAT_MODE_LSB 0
`define AMCS_STAT_MODE_MSB 2
`define AMCS_STAT_BUSMODE 3
`define AMCS_STAT_MASTER 4
`define AMCS_STAT_ON 5
`define AMCS_STAT_MUTEPIN 6

// operating states
`define AMCS_ST_OFF 3'h0
`define AMCS_ST_STANDBY 3'h1
`define AMCS_ST_MUTE 3'h2
`define AMCS_ST_OPER 3'h3
`define AMCS_ST_WAIT 3'h4

// pwm counter: last count of the 256-tick period, half for idle duty
`define AMCS_PWM_W 8
`define AMCS_PWM_PERIOD 8'hFF
`define AMCS_PWM_HALF 8'h80
`define AMCS_PWM_RESET 8'h80

// master clock divider: toggle every this many pclk cycles
`define AMCS_DIV_W 4
`define AMCS_DIV_HALF 4'h4

`endif

//--- rtl/amcs_sync.v
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
`include "amcs_consts.vh"
module amcs_sync (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // level in and out
    input wire d,
    output reg q_ff
);
reg meta_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_ff <= 1'h0;
        q_ff <= 1'h0;
    end else begin
        meta_ff <= d;
        q_ff <= meta_ff;
    end
end
endmodule
`default_nettype wire

//--- rtl/amcs_pwm.v
// pwm modulator for one bridge, switched at the oscillator tick
`timescale 1ns/1ns
`default_nettype none
`include "amcs_consts.vh"
module amcs_pwm (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // oscillator tick and control
    input wire osc_tick,
    input wire run,
    input wire mute,
    input wire [7:0] level,
    // bridge output
    output reg pwm_ff
);
reg [7:0] cnt_ff;
wire [7:0] nxt_cnt;
wire [7:0] duty;
assign nxt_cnt = (cnt_ff == `AMCS_PWM_PERIOD) ? 8'h00 : cnt_ff + 8'h01;
// mute forces idle half duty instead of audio
assign duty = mute ? `AMCS_PWM_HALF : level;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_ff <= 8'h00;
        pwm_ff <= 1'h0;
    end else if (!run) begin
        cnt_ff <= 8'h00;
        pwm_ff <= 1'h0;
    end else if (osc_tick) begin
        cnt_ff <= nxt_cnt;
        pwm_ff <= (cnt_ff < duty);
    end
end
endmodule
`default_nettype wire

//--- rtl/amcs_top.v
// amplifier mode controller and clock master/slave select with apb registers
//
// Notes on behaviour
// - chip-on low: amplifier off but master clock still driven, every bus write ignored.
// - resistor on address-select pin: bus-controlled mode.
// - address-select pin grounded: pin-controlled mode.
// - bus mode, chip on: wait idle until bus commands arrive; standby instead while mute-select is low.
// - pin mode comes up muted by default.
// - mute: bridges switch at half duty, audio suppressed.
// - pin mode, chip on: mute-select high gives operating, low gives mute.
// - bus mode: bits and mute-select pick operating, mute or standby.
// - output is pwm switched at the oscillator clock.
// - oscillator-setting resistor: master, drive own clock out.
// - oscillator-setting grounded: slave, switch from external clock.
`timescale 1ns/1ns
`default_nettype none
`include "amcs_consts.vh"
module amcs_top (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // mode pins
    input wire chip_on_pin,
    input wire mute_select_pin,
    input wire bus_address_select_pin,
    input wire oscillator_setting_pin,
    // oscillator clock pin, three signals
    input wire oscillator_clock_pin_i,
    output reg oscillator_clock_pin_o_ff,
    output reg oscillator_clock_pin_oe_ff,
    // audio levels and bridge outputs
    input wire [7:0] audio_ch1,
    input wire [7:0] audio_ch2,
    output reg out_ch1_ff,
    output reg out_ch2_ff,
    // state outputs
    output reg [2:0] amp_state_ff
);
// strap pins: high means a resistor is fitted, low means shorted to ground
wire chip_on_s;
wire mute_sel_s;
wire ads_s;
wire osc_s;
wire ext_clk_s;

amcs_sync u_sync_on (.pclk(pclk), .presetn(presetn), .d(chip_on_pin), .q_ff(chip_on_s));
amcs_sync u_sync_mute (.pclk(pclk), .presetn(presetn), .d(mute_select_pin), .q_ff(mute_sel_s));
amcs_sync u_sync_ads (.pclk(pclk), .presetn(presetn), .d(bus_address_select_pin),
    .q_ff(ads_s));
amcs_sync u_sync_osc (.pclk(pclk), .presetn(presetn), .d(oscillator_setting_pin),
    .q_ff(osc_s));
amcs_sync u_sync_clk (.pclk(pclk), .presetn(presetn), .d(oscillator_clock_pin_i),
    .q_ff(ext_clk_s));

// straps are caught once after reset release, never under reset itself
// two settle flops: the strap syncs show the pin only from the second edge
reg strap_done_ff;
reg strap_wait_ff;
reg strap_settle_ff;
reg bus_mode_ff;
reg master_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strap_wait_ff <= 1'h0;
        strap_settle_ff <= 1'h0;
        strap_done_ff <= 1'h0;
        bus_mode_ff <= 1'h0;
        master_ff <= 1'h0;
    end else begin
        strap_wait_ff <= 1'h1;
        strap_settle_ff <= strap_wait_ff;
        if (strap_settle_ff && !strap_done_ff) begin
            strap_done_ff <= 1'h1;
            bus_mode_ff <= ads_s;
            master_ff <= osc_s;
        end
    end
end

// control register, written only while the chip is on
reg amp_active_bit_ff;
reg mute_request_bit_ff;
reg [7:0] pwm_level_ff;
wire wr_en;
wire rd_en;
wire addr_ok;
assign wr_en = psel && penable && pwrite && pready_ff;
assign rd_en = psel && penable && !pwrite && pready_ff;
assign addr_ok = (paddr == `AMCS_ADDR_CTRL) || (paddr == `AMCS_ADDR_STRAP) ||
    (paddr == `AMCS_ADDR_STATUS) || (paddr == `AMCS_ADDR_PWM);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        amp_active_bit_ff <= 1'h0;
        mute_request_bit_ff <= 1'h0;
        pwm_level_ff <= `AMCS_PWM_RESET;
    end else if (!chip_on_s) begin
        amp_active_bit_ff <= 1'h0;
        mute_request_bit_ff <= 1'h0;
    end else if (wr_en && bus_mode_ff && paddr == `AMCS_ADDR_CTRL) begin
        amp_active_bit_ff <= pwdata[`AMCS_CTRL_ACTIVE];
        mute_request_bit_ff <= pwdata[`AMCS_CTRL_MUTE];
    end else if (wr_en && paddr == `AMCS_ADDR_PWM) begin
        pwm_level_ff <= pwdata[`AMCS_PWM_W-1:0];
    end
end

// mode decode
reg [2:0] nxt_state;
always @* begin
    nxt_state = `AMCS_ST_OFF;
    if (!strap_done_ff || !chip_on_s) begin
        nxt_state = `AMCS_ST_OFF;
    end else if (!bus_mode_ff) begin
        nxt_state = mute_sel_s ? `AMCS_ST_OPER : `AMCS_ST_MUTE;
    end else begin
        if (amp_active_bit_ff && mute_sel_s && !mute_request_bit_ff) begin
            nxt_state = `AMCS_ST_OPER;
        end else if (amp_active_bit_ff && !mute_sel_s && mute_request_bit_ff) begin
            nxt_state = `AMCS_ST_MUTE;
        end else if (!amp_active_bit_ff && !mute_sel_s) begin
            nxt_state = `AMCS_ST_STANDBY;
        end else begin
            nxt_state = `AMCS_ST_WAIT;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        amp_state_ff <= `AMCS_ST_OFF;
    end else begin
        amp_state_ff <= nxt_state;
    end
end

// oscillator: master divides pclk, slave edge-detects the synced pin
reg [3:0] div_ff;
reg int_clk_ff;
reg ext_prev_ff;
wire osc_tick;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_ff <= 4'h0;
        int_clk_ff <= 1'h0;
        ext_prev_ff <= 1'h0;
    end else begin
        ext_prev_ff <= ext_clk_s;
        if (div_ff == `AMCS_DIV_HALF - 4'h1) begin
            div_ff <= 4'h0;
            int_clk_ff <= ~int_clk_ff;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
end
// slave ticks on external rising edge
assign osc_tick = master_ff ? (div_ff == `AMCS_DIV_HALF - 4'h1 && !int_clk_ff) :
    (ext_clk_s && !ext_prev_ff);

// only one master on the shared pin
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        oscillator_clock_pin_o_ff <= 1'h0;
        oscillator_clock_pin_oe_ff <= 1'h0;
    end else begin
        oscillator_clock_pin_o_ff <= int_clk_ff;
        oscillator_clock_pin_oe_ff <= master_ff && strap_done_ff;
    end
end

// bridges run in mute and operating only; mute forces half duty
wire run;
wire mute;
wire [2*`AMCS_PWM_W-1:0] levels;
wire [1:0] pwm;
assign run = (amp_state_ff == `AMCS_ST_OPER) || (amp_state_ff == `AMCS_ST_MUTE);
assign mute = (amp_state_ff == `AMCS_ST_MUTE);
assign levels = {audio_ch2, audio_ch1};
// one modulator per channel, both on the shared oscillator tick
genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
        amcs_pwm u_amcs_pwm (
            .pclk(pclk),
            .presetn(presetn),
            .osc_tick(osc_tick),
            .run(run),
            .mute(mute),
            .level(levels[ch*`AMCS_PWM_W +: `AMCS_PWM_W]),
            .pwm_ff(pwm[ch])
        );
    end
endgenerate
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_ch1_ff <= 1'h0;
        out_ch2_ff <= 1'h0;
    end else begin
        out_ch1_ff <= pwm[0];
        out_ch2_ff <= pwm[1];
    end
end

// apb: one wait state so every access takes setup plus two cycles
reg [31:0] nxt_rdata;
always @* begin
    nxt_rdata = 32'h00000000;
    case (paddr)
        `AMCS_ADDR_CTRL: begin
            nxt_rdata[`AMCS_CTRL_ACTIVE] = amp_active_bit_ff;
            nxt_rdata[`AMCS_CTRL_MUTE] = mute_request_bit_ff;
        end
        `AMCS_ADDR_STRAP: begin
            nxt_rdata[`AMCS_STRAP_ADS_RES] = bus_mode_ff;
            nxt_rdata[`AMCS_STRAP_OSC_RES] = master_ff;
        end
        `AMCS_ADDR_STATUS: begin
            nxt_rdata[`AMCS_STAT_MODE_MSB:`AMCS_STAT_MODE_LSB] = amp_state_ff;
            nxt_rdata[`AMCS_STAT_BUSMODE] = bus_mode_ff;
            nxt_rdata[`AMCS_STAT_MASTER] = master_ff;
            nxt_rdata[`AMCS_STAT_ON] = chip_on_s;
            nxt_rdata[`AMCS_STAT_MUTEPIN] = mute_sel_s;
        end
        `AMCS_ADDR_PWM: begin
            nxt_rdata[`AMCS_PWM_W-1:0] = pwm_level_ff;
        end
        default: begin
            nxt_rdata = 32'h00000000;
        end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_ff <= 1'h0;
        pslverr_ff <= 1'h0;
        prdata_ff <= 32'h00000000;
    end else begin
        pready_ff <= psel && penable && !pready_ff;
        pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
        if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end else if (rd_en) begin
            prdata_ff <= 32'h00000000;
        end
    end
end
endmodule
`default_nettype wire

//--- sim/amcs_monitor.sv
// port assertions for the mode controller
`timescale 1ns/1ns
`default_nettype none
`include "amcs_consts.vh"
module amcs_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata_ff,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    // pins and outputs
    input wire logic chip_on_pin,
    input wire logic mute_select_pin,
    input wire logic bus_address_select_pin,
    input wire logic oscillator_setting_pin,
    input wire logic oscillator_clock_pin_o_ff,
    input wire logic oscillator_clock_pin_oe_ff,
    input wire logic out_ch1_ff,
    input wire logic out_ch2_ff,
    input wire logic [2:0] amp_state_ff
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire quiet = amp_state_ff != `AMCS_ST_MUTE && amp_state_ff != `AMCS_ST_OPER;
    wire mapped = paddr == `AMCS_ADDR_CTRL || paddr == `AMCS_ADDR_STRAP ||
        paddr == `AMCS_ADDR_STATUS || paddr == `AMCS_ADDR_PWM;
    // pins pass one two-flop sync and a state flop, so eight samples is ample
    sequence s_pin_hi;
        (chip_on_pin && !bus_address_select_pin && mute_select_pin)[*8];
    endsequence
    sequence s_pin_lo;
        (chip_on_pin && !bus_address_select_pin && !mute_select_pin)[*8];
    endsequence
    sequence s_half_hi;
        oscillator_clock_pin_o_ff[*4] ##1 !oscillator_clock_pin_o_ff;
    endsequence
    a_off_when_down: assert property ((!chip_on_pin)[*4] |->
        amp_state_ff == `AMCS_ST_OFF) else $error("state not off");
    a_quiet_bridges: assert property (quiet[*3] |->
        !out_ch1_ff && !out_ch2_ff) else $error("bridges switch when idle");
    a_pin_mute: assert property (s_pin_lo |->
        amp_state_ff == `AMCS_ST_MUTE) else $error("pin mode not muted");
    a_pin_oper: assert property (s_pin_hi |->
        amp_state_ff == `AMCS_ST_OPER) else $error("pin mode not operating");
    a_master_drive: assert property (oscillator_setting_pin[*8] |->
        oscillator_clock_pin_oe_ff) else $error("master not driving");
    a_slave_input: assert property ((!oscillator_setting_pin)[*8] |->
        !oscillator_clock_pin_oe_ff) else $error("slave drives clock");
    a_master_rate: assert property ($rose(oscillator_clock_pin_o_ff) &&
        oscillator_clock_pin_oe_ff |-> s_half_hi) else $error("clock rate wrong");
    a_apb_wait: assert property ($rose(penable) && psel |->
        !pready_ff ##1 pready_ff) else $error("apb wait wrong");
    a_apb_unmapped: assert property (pready_ff |->
        pslverr_ff == !mapped && (!pslverr_ff || prdata_ff == 32'h0))
        else $error("apb error response wrong");
    a_ready_pulse: assert property (pready_ff |=>
        !pready_ff) else $error("ready longer than one cycle");
endmodule
bind amcs_top amcs_monitor u_amcs_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata_ff(prdata_ff),
    .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff),
    .chip_on_pin(chip_on_pin),
    .mute_select_pin(mute_select_pin),
    .bus_address_select_pin(bus_address_select_pin),
    .oscillator_setting_pin(oscillator_setting_pin),
    .oscillator_clock_pin_o_ff(oscillator_clock_pin_o_ff),
    .oscillator_clock_pin_oe_ff(oscillator_clock_pin_oe_ff),
    .out_ch1_ff(out_ch1_ff),
    .out_ch2_ff(out_ch2_ff),
    .amp_state_ff(amp_state_ff)
);
`default_nettype wire

//--- sim/amcs_host.sv
// far side: another chip sharing the oscillator clock wire
`timescale 1ns/1ns
`default_nettype none
module amcs_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // shared clock wire
    input wire logic dut_oe,
    input wire logic dut_o,
    output wire logic line
);
    logic [2:0] cnt_ff;
    logic clk_ff;
    assign line = dut_oe ? dut_o : clk_ff;
    // free running external clock, period ten cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 3'h0;
            clk_ff <= 1'h0;
        end else if (cnt_ff == 3'h4) begin
            cnt_ff <= 3'h0;
            clk_ff <= ~clk_ff;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
endmodule
`default_nettype wire

//--- sim/amcs_top_tb.sv
// self-checking bench for the mode controller
`timescale 1ns/1ns
`default_nettype none
`include "amcs_consts.vh"
module amcs_top_tb;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic chip_on_pin, mute_select_pin, bus_address_select_pin, oscillator_setting_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [7:0] audio_ch1, audio_ch2;
    wire [31:0] prdata_ff;
    wire pready_ff, pslverr_ff, osc_o, osc_oe, osc_line, out_ch1_ff, out_ch2_ff;
    wire [2:0] amp_state_ff;
    int fails, compares, cyc;
    amcs_top u_amcs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_ff, .pready_ff, .pslverr_ff, .chip_on_pin, .mute_select_pin,
        .bus_address_select_pin, .oscillator_setting_pin,
        .oscillator_clock_pin_i(osc_line), .oscillator_clock_pin_o_ff(osc_o),
        .oscillator_clock_pin_oe_ff(osc_oe), .audio_ch1, .audio_ch2,
        .out_ch1_ff, .out_ch2_ff, .amp_state_ff);
    amcs_host u_amcs_host (.pclk, .presetn, .dut_oe(osc_oe), .dut_o(osc_o), .line(osc_line));
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            results;
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // only the bench timeout ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'h1);
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rst(logic a, logic o);
        presetn <= 1'h0;
        bus_address_select_pin <= a;
        oscillator_setting_pin <= o;
        chip_on_pin <= 1'h0;
        mute_select_pin <= 1'h0;
        wt(10);
        presetn <= 1'h1;
        wt(8);
    endtask
    // whole pwm periods, so the count is exact whatever the phase
    task automatic duty(int n, int e1, int e2);
        int h1, h2;
        h1 = 0;
        h2 = 0;
        repeat (n) begin
            @(posedge pclk);
            if (out_ch1_ff === 1'h1) h1++;
            if (out_ch2_ff === 1'h1) h2++;
        end
        check("duty ch1", h1, e1);
        check("duty ch2", h2, e2);
    endtask
    task automatic t_pin;
        rst(1'h0, 1'h1);
        apb(1'h0, `AMCS_ADDR_STRAP, 32'h0);
        check("strap", rd, 32'h2);
        check("slverr", err, 1'h0);
        chip_on_pin <= 1'h1;
        wt(8);
        check("state", amp_state_ff, `AMCS_ST_MUTE);
        check("oe", osc_oe, 1'h1);
        apb(1'h1, `AMCS_ADDR_CTRL, 32'h3);
        apb(1'h0, `AMCS_ADDR_CTRL, 32'h0);
        check("ctrl pin mode", rd, 32'h0);
        check("state", amp_state_ff, `AMCS_ST_MUTE);
        duty(2048, 1024, 1024);
        mute_select_pin <= 1'h1;
        wt(8);
        check("state", amp_state_ff, `AMCS_ST_OPER);
        duty(2048, 512, 1536);
        chip_on_pin <= 1'h0;
        wt(8);
        check("state", amp_state_ff, `AMCS_ST_OFF);
    endtask
    task automatic t_bus;
        logic [31:0] ctl [3] = '{32'h3, 32'h1, 32'h0};
        logic mp [3] = '{1'h0, 1'h1, 1'h0};
        logic [2:0] st [3] = '{`AMCS_ST_MUTE, `AMCS_ST_OPER, `AMCS_ST_STANDBY};
        rst(1'h1, 1'h0);
        mute_select_pin <= 1'h1;
        chip_on_pin <= 1'h1;
        wt(8);
        check("state", amp_state_ff, `AMCS_ST_WAIT);
        check("oe", osc_oe, 1'h0);
        apb(1'h0, `AMCS_ADDR_STRAP, 32'h0);
        check("strap", rd, 32'h1);
        apb(1'h0, `AMCS_ADDR_PWM, 32'h0);
        check("pwm reg", rd, 32'h80);
        apb(1'h1, `AMCS_ADDR_PWM, 32'h5A);
        apb(1'h0, `AMCS_ADDR_PWM, 32'h0);
        check("pwm reg written", rd, 32'h5A);
        apb(1'h0, 12'h010, 32'h0);
        check("slverr", err, 1'h1);
        check("unmapped data", rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, `AMCS_ADDR_CTRL, ctl[i]);
            mute_select_pin <= mp[i];
            wt(6);
            apb(1'h0, `AMCS_ADDR_STATUS, 32'h0);
            // mute pin, chip on, slave, bus mode, then state
            check("status", rd, {25'h0, mp[i], 3'h5, st[i]});
            if (i == 0) duty(2560, 1280, 1280);
        end
        chip_on_pin <= 1'h0;
        wt(6);
        apb(1'h1, `AMCS_ADDR_CTRL, 32'h3);
        apb(1'h0, `AMCS_ADDR_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        check("state", amp_state_ff, `AMCS_ST_OFF);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, chip_on_pin, mute_select_pin} = 6'h0;
        {bus_address_select_pin, oscillator_setting_pin, paddr, pwdata} = 46'h0;
        audio_ch1 = 8'h40;
        audio_ch2 = 8'hC0;
        fails = 0;
        compares = 0;
        cyc = 0;
        t_pin;
        t_bus;
        results;
    end
endmodule
`default_nettype wire
